// File: hw/qabort_defs.svh
// constants for the queued command abort handler: codes, fields, offsets
// assumes inclusion from the package, the design modules, the checker and the test
`ifndef QABORT_DEFS_SVH
`define QABORT_DEFS_SVH
`define CMD_QUEUE_MGMT      8'h63
`define SUB_ABORT           4'h0
`define SUB_DEADLINE        4'h1
`define FEAT_SUB_LSB        0
`define FEAT_TYPE_LSB       4
`define SLOT_LSB            3
`define ABORT_ALL           4'h0
`define ABORT_STREAM        4'h1
`define ABORT_NONSTREAM     4'h2
`define ABORT_SELECTED      4'h3
`define ERR_ABORTED_BIT     2
`define STAT_OCCUPIED_BIT   7
`define STAT_READY_BIT      6
`define STAT_SEEK_BIT       4
`define STAT_ERROR_BIT      0
`define REG_CONTROL         4'h0
`define REG_SUPPORT         4'h1
`define REG_ERROR           4'h2
`define REG_STATUS          4'h3
`define REG_IRQ_STATUS      4'h4
`define REG_IRQ_MASK        4'h5
`define REG_LAST_MASK       4'h6
`define REG_TYPE_SUPPORT_RESET 8'h0F
`define ERROR_CLEAR         8'h00
`define STATUS_IDLE         8'h50
`define ERROR_REFUSED       8'h04
`define STATUS_REFUSED      8'h51
`endif

// File: hw/qabort_pkg.sv
// types shared by the queued command abort handler
// assumes the defs header sits beside it
`include "qabort_defs.svh"
package qabort_pkg;
    typedef enum logic [1:0]
    {
        st_idle  = 2'b00,
        st_check = 2'b01,
        st_send  = 2'b11,
        st_done  = 2'b10
    } handler_state_t;
    typedef logic [4:0] slot_t;
endpackage

// File: hw/slot_selector.sv
// builds the mask of outstanding slots hit by one abort type
// assumes the outstanding and streaming masks are stable while it is read
`timescale 1ns/1ns
`include "qabort_defs.svh"
module slot_selector
    import qabort_pkg::*;
#(
    parameter int SLOTS = 32
)
(
    input  wire logic [3:0]       abort_type,
    input  wire logic [4:0]       target_slot,
    input  wire logic [SLOTS-1:0] outstanding,
    input  wire logic [SLOTS-1:0] streaming,
    output logic      [SLOTS-1:0] hit_mask
);
    // pick slots by abort type
    always_comb
    begin
        hit_mask = '0;
        case (abort_type)
            `ABORT_ALL:       hit_mask = outstanding;
            `ABORT_STREAM:    hit_mask = outstanding & streaming;
            `ABORT_NONSTREAM: hit_mask = outstanding & ~streaming;
            `ABORT_SELECTED:  hit_mask[target_slot] = outstanding[target_slot];
            default:          hit_mask = '0;
        endcase
    end
endmodule // slot_selector

// File: hw/queued_command_abort_handler.sv
// queue management command decode with queue abort subcommand
// assumes task-file bytes arrive with a one-cycle command strobe, synchronous to mclk
//
// The plain strobed port and the register offsets were decided locally.
`timescale 1ns/1ns
`include "qabort_defs.svh"
// Overview of operation
// - command code 63h selects the queue management command
// - subcommand 0h is queue abort; outputs depend on subcommand
// - subcommand 1h is deadline handling, kept apart from abort
// - supported abort type succeeds even with nothing aborted
// - success sends set-device-bits with abort and aborted slots set
// - that completion may also carry independently finished slots
// - reject with aborted error when queuing is disabled
// - reject when target slot equals the abort command's own slot
// - reject when target slot is not a valid queue slot
// - reject when abort type is unsupported
// - subcommand in feature bits 3..0, abort type in bits 7..4
// - types: 0 all, 1 streaming, 2 non-streaming, 3 selected slot
// - target slot in sector number bits 7..3, used only for type 3
module queued_command_abort_handler
    import qabort_pkg::*;
#(
    parameter int SLOTS = 32
)
(
    input  wire logic             mclk,
    input  wire logic             nrst,
    input  wire logic             clk_en,
    // task file from the link
    input  wire logic             cmd_valid,
    input  wire logic [7:0]       cmd_code,
    input  wire logic [7:0]       feature_cur,
    input  wire logic [7:0]       sector_count_cur,
    input  wire logic [7:0]       sector_number_cur,
    input  wire logic             queuing_enabled,
    input  wire logic [4:0]       max_slot,
    // queue state from the device core
    input  wire logic [SLOTS-1:0] outstanding,
    input  wire logic [SLOTS-1:0] streaming,
    input  wire logic [SLOTS-1:0] finished,
    // completion towards the link
    output logic                  sdb_valid,
    output logic [SLOTS-1:0]      outstanding_command_mask,
    output logic                  error_valid,
    output logic                  abort_request,
    output logic [SLOTS-1:0]      abort_slots,
    output logic                  deadline_request,
    output logic                  other_command,
    // register port
    input  wire logic [3:0]       reg_addr,
    input  wire logic [7:0]       reg_wdata,
    input  wire logic             reg_wr,
    input  wire logic             reg_rd,
    output logic [7:0]            reg_rdata,
    output logic                  irq
);
    // the last-mask register reads eight slots, the slot fields reach 32
    if (SLOTS < 8 || SLOTS > 32)
    begin : g_slots_check
        $error("SLOTS must lie between 8 and 32");
    end

    handler_state_t   state;
    logic [7:0]       command_error_flags;
    logic [7:0]       command_status_flags;
    logic [7:0]       type_support;
    logic             handler_enable;
    logic [1:0]       irq_status;
    logic [1:0]       irq_mask;
    logic [3:0]       abort_type;
    slot_t            own_slot;
    slot_t            abort_target_slot;
    logic [SLOTS-1:0] hit_mask;
    logic [SLOTS-1:0] next_mask;
    logic             reject;
    logic             ev_done;
    logic             ev_error;
    logic             take_cmd;

    // slot field from a task-file byte
    function automatic slot_t slot_of(input logic [7:0] b);
        slot_of = b[7:`SLOT_LSB];
    endfunction

    // one-hot bit for a slot number
    function automatic logic [SLOTS-1:0] slot_bit(input slot_t s);
        logic [SLOTS-1:0] m;
        m = '0;
        m[s] = 1'b1;
        slot_bit = m;
    endfunction

    // subcommand field of the feature byte
    function automatic logic [3:0] sub_of(input logic [7:0] b);
        sub_of = b[`FEAT_SUB_LSB+3:`FEAT_SUB_LSB];
    endfunction

    // abort type field of the feature byte
    function automatic logic [3:0] type_of(input logic [7:0] b);
        type_of = b[`FEAT_TYPE_LSB+3:`FEAT_TYPE_LSB];
    endfunction

    // a task file is taken only in idle with the handler enabled
    assign take_cmd = (state == st_idle) && cmd_valid && handler_enable;

    slot_selector #(
        .SLOTS (SLOTS)
    ) u_sel (
        .abort_type  (abort_type),
        .target_slot (abort_target_slot),
        .outstanding (outstanding),
        .streaming   (streaming),
        .hit_mask    (hit_mask)
    );

    // acceptance checks on the latched request
    always_comb
    begin
        reject = 1'b0;
        if (!queuing_enabled)
            reject = 1'b1;
        if (!type_support[abort_type[2:0]] || abort_type[3])
            reject = 1'b1;
        if (abort_type == `ABORT_SELECTED)
        begin
            if (abort_target_slot == own_slot)
                reject = 1'b1;
            if (abort_target_slot > max_slot || 32'(abort_target_slot) >= SLOTS)
                reject = 1'b1;
        end
        // own slot plus aborted plus independently finished ones
        next_mask = slot_bit(own_slot) | hit_mask | finished;
    end

    // command decode and completion sequence
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            state             <= st_idle;
            abort_type        <= 4'h0;
            own_slot          <= '0;
            abort_target_slot <= '0;
        end
        else if (clk_en)
        begin
            case (state)
                st_idle:
                begin
                    if (take_cmd && cmd_code == `CMD_QUEUE_MGMT
                        && sub_of(feature_cur) == `SUB_ABORT)
                    begin
                        abort_type        <= type_of(feature_cur);
                        own_slot          <= slot_of(sector_count_cur);
                        abort_target_slot <= slot_of(sector_number_cur);
                        state             <= st_check;
                    end
                end
                st_check: state <= reject ? st_done : st_send;
                st_send:  state <= st_done;
                st_done:  state <= st_idle;
                default:  state <= st_idle;
            endcase
        end
    end

    // outward strobes of one cycle each, with the two slot masks held until replaced
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            sdb_valid                <= 1'b0;
            outstanding_command_mask <= '0;
            error_valid              <= 1'b0;
            abort_request            <= 1'b0;
            abort_slots              <= '0;
            deadline_request         <= 1'b0;
            other_command            <= 1'b0;
        end
        else if (clk_en)
        begin
            sdb_valid        <= 1'b0;
            error_valid      <= 1'b0;
            abort_request    <= 1'b0;
            deadline_request <= 1'b0;
            other_command    <= 1'b0;
            if (take_cmd)
            begin
                if (cmd_code != `CMD_QUEUE_MGMT)
                    other_command <= 1'b1;
                else if (sub_of(feature_cur) == `SUB_DEADLINE)
                    deadline_request <= 1'b1;
                else if (sub_of(feature_cur) != `SUB_ABORT)
                    error_valid <= 1'b1;
            end
            if (state == st_check && !reject)
            begin
                abort_request <= 1'b1;
                abort_slots   <= hit_mask;
            end
            if (state == st_check && reject)
                error_valid <= 1'b1;
            if (state == st_send)
            begin
                sdb_valid                <= 1'b1;
                outstanding_command_mask <= next_mask;
            end
        end
    end

    // error and status bytes as reported to the host
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            command_error_flags  <= `ERROR_CLEAR;
            command_status_flags <= `STATUS_IDLE;
        end
        else if (clk_en)
        begin
            if (state == st_check && reject)
            begin
                command_error_flags  <= 8'h00;
                command_error_flags[`ERR_ABORTED_BIT] <= 1'b1;
                command_status_flags <= 8'h00;
                command_status_flags[`STAT_READY_BIT] <= 1'b1;
                command_status_flags[`STAT_SEEK_BIT]  <= 1'b1;
                command_status_flags[`STAT_ERROR_BIT] <= 1'b1;
            end
            else if (state == st_check)
            begin
                command_error_flags  <= `ERROR_CLEAR;
                command_status_flags <= `STATUS_IDLE;
            end
            else if (take_cmd && cmd_code == `CMD_QUEUE_MGMT
                     && sub_of(feature_cur) != `SUB_ABORT
                     && sub_of(feature_cur) != `SUB_DEADLINE)
            begin
                // unknown subcommand is refused like a bad abort
                command_error_flags  <= `ERROR_REFUSED;
                command_status_flags <= `STATUS_REFUSED;
            end
            // busy bit stays clear throughout
            command_status_flags[`STAT_OCCUPIED_BIT] <= 1'b0;
        end
    end

    assign ev_done  = (state == st_send);
    assign ev_error = error_valid;

    // software control and support registers
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            handler_enable <= 1'b1;
            type_support   <= `REG_TYPE_SUPPORT_RESET;
            irq_mask       <= 2'b00;
        end
        else if (clk_en && reg_wr)
        begin
            case (reg_addr)
                `REG_CONTROL:  handler_enable <= reg_wdata[0];
                `REG_SUPPORT:  type_support   <= reg_wdata;
                `REG_IRQ_MASK: irq_mask       <= reg_wdata[1:0];
                default:       ;
            endcase
        end
    end

    // sticky events, write one to clear, set wins
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
            irq_status <= 2'b00;
        else if (clk_en)
        begin
            irq_status <= (irq_status
                           & ~((reg_wr && reg_addr == `REG_IRQ_STATUS) ? reg_wdata[1:0] : 2'b00))
                          | {ev_error, ev_done};
        end
    end

    // interrupt level from a flip-flop
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
            irq <= 1'b0;
        else if (clk_en)
            irq <= |(((irq_status
                       & ~((reg_wr && reg_addr == `REG_IRQ_STATUS) ? reg_wdata[1:0] : 2'b00))
                      | {ev_error, ev_done}) & irq_mask);
    end

    // read data one cycle after the strobe, zero otherwise
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
            reg_rdata <= 8'h00;
        else if (clk_en)
        begin
            reg_rdata <= 8'h00;
            if (reg_rd)
            begin
                case (reg_addr)
                    `REG_CONTROL:    reg_rdata <= {7'h00, handler_enable};
                    `REG_SUPPORT:    reg_rdata <= type_support;
                    `REG_ERROR:      reg_rdata <= command_error_flags;
                    `REG_STATUS:     reg_rdata <= command_status_flags;
                    `REG_IRQ_STATUS: reg_rdata <= {6'h00, irq_status};
                    `REG_IRQ_MASK:   reg_rdata <= {6'h00, irq_mask};
                    `REG_LAST_MASK:  reg_rdata <= outstanding_command_mask[7:0];
                    default:         reg_rdata <= 8'h00;
                endcase
            end
        end
    end
endmodule // queued_command_abort_handler

// File: testbench/qabort_chk.sv
// port checker of the queued command abort handler
// assumes the bind below and one clock domain, mclk with nrst
`timescale 1ns/1ns
`include "qabort_defs.svh"
module qabort_chk
    import qabort_pkg::*;
#(
    parameter int SLOTS = 32
)
(
    input wire logic             mclk,
    input wire logic             nrst,
    input wire logic             clk_en,
    input wire logic             cmd_valid,
    input wire logic [7:0]       cmd_code,
    input wire logic [7:0]       feature_cur,
    input wire logic [7:0]       sector_count_cur,
    input wire logic [7:0]       sector_number_cur,
    input wire logic             queuing_enabled,
    input wire logic [4:0]       max_slot,
    input wire logic             sdb_valid,
    input wire logic [SLOTS-1:0] outstanding_command_mask,
    input wire logic             error_valid,
    input wire logic             abort_request,
    input wire logic [SLOTS-1:0] abort_slots,
    input wire logic             deadline_request,
    input wire logic             other_command,
    input wire logic [3:0]       reg_addr,
    input wire logic [7:0]       reg_wdata,
    input wire logic             reg_wr
);
    default clocking @(posedge mclk);
    endclocking
    default disable iff (!nrst);
    logic [1:0] busy;
    logic       en;
    logic [4:0] own;
    logic       take;
    logic       abort;
    logic       sel;
    // a task file the handler takes, and an abort among them
    assign take  = cmd_valid && clk_en && en && busy == 2'd0;
    assign abort = take && cmd_code == `CMD_QUEUE_MGMT && feature_cur[3:0] == `SUB_ABORT;
    assign sel   = abort && queuing_enabled && feature_cur[7:4] == `ABORT_SELECTED;
    // enable bit, busy span and own slot of the last abort
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            busy <= 2'd0;
            en   <= 1'b1;
            own  <= 5'd0;
        end
        else if (clk_en)
        begin
            if (reg_wr && reg_addr == `REG_CONTROL)
                en <= reg_wdata[0];
            if (abort)
            begin
                busy <= 2'd3;
                own  <= sector_count_cur[7:3];
            end
            else if (busy != 2'd0)
                busy <= busy - 2'd1;
        end
    end
    sequence accept_seq;
        abort_request ##1 sdb_valid;
    endsequence
    AST_ACCEPT: assert property (
        abort && queuing_enabled && feature_cur[7:4] == `ABORT_ALL |-> ##2 accept_seq)
        else $error("supported abort not completed");
    AST_OTHER: assert property (
        take && cmd_code != `CMD_QUEUE_MGMT |=> other_command)
        else $error("other command not flagged");
    AST_DEADLINE: assert property (
        take && cmd_code == `CMD_QUEUE_MGMT && feature_cur[3:0] == `SUB_DEADLINE
        |=> deadline_request && !abort_request)
        else $error("deadline subcommand not flagged");
    AST_DISABLED: assert property (
        abort && !queuing_enabled |-> ##2 error_valid && !abort_request)
        else $error("abort with queuing off not refused");
    AST_SELF: assert property (
        sel && sector_number_cur[7:3] == sector_count_cur[7:3] |-> ##2 error_valid)
        else $error("abort of own slot not refused");
    AST_INVALID: assert property (
        sel && sector_number_cur[7:3] > max_slot |-> ##2 error_valid)
        else $error("invalid target slot not refused");
    AST_UNSUP: assert property (
        abort && feature_cur[7] |-> ##2 error_valid)
        else $error("unsupported abort type not refused");
    AST_OWN_SET: assert property (
        sdb_valid |-> outstanding_command_mask[own])
        else $error("own slot missing from completion");
    AST_SUBSET: assert property (
        sdb_valid |-> ($past(abort_slots) & ~outstanding_command_mask) == '0)
        else $error("aborted slot missing from completion");
    AST_EXCL: assert property (
        error_valid |-> !abort_request && !sdb_valid)
        else $error("refusal and completion together");
endmodule // qabort_chk

bind queued_command_abort_handler qabort_chk #(.SLOTS(SLOTS)) qabort_chk_i
(
    .mclk(mclk), .nrst(nrst), .clk_en(clk_en), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .feature_cur(feature_cur), .sector_count_cur(sector_count_cur),
    .sector_number_cur(sector_number_cur), .queuing_enabled(queuing_enabled),
    .max_slot(max_slot), .sdb_valid(sdb_valid), .error_valid(error_valid),
    .outstanding_command_mask(outstanding_command_mask), .abort_request(abort_request),
    .abort_slots(abort_slots), .deadline_request(deadline_request),
    .other_command(other_command), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr)
);

// File: testbench/host_model.sv
// host side model: sends one task file per call with abort spacing
// assumes the caller waits for each send to return
`timescale 1ns/1ns
module host_model
(
    input  wire logic  mclk,
    output logic       cmd_valid,
    output logic [7:0] cmd_code,
    output logic [7:0] feature_cur,
    output logic [7:0] sector_count_cur,
    output logic [7:0] sector_number_cur
);
    // idle task file at time zero
    initial
    begin
        cmd_valid         = 1'b0;
        cmd_code          = 8'h00;
        feature_cur       = 8'h00;
        sector_count_cur  = 8'h00;
        sector_number_cur = 8'h00;
    end
    // one strobe cycle, then bytes inverted once released
    task automatic send(input logic [7:0] code, input logic [7:0] feat,
                        input logic [4:0] own_slot, input logic [4:0] target);
        @(posedge mclk);
        cmd_valid         <= 1'b1;
        cmd_code          <= code;
        feature_cur       <= feat;
        sector_count_cur  <= {own_slot, 3'h0};
        sector_number_cur <= {target, 3'h0};
        @(posedge mclk);
        cmd_valid         <= 1'b0;
        cmd_code          <= ~code;
        feature_cur       <= ~feat;
        sector_count_cur  <= ~sector_count_cur;
        sector_number_cur <= ~sector_number_cur;
        repeat (4) @(posedge mclk);
    endtask
endmodule // host_model

// File: testbench/queued_command_abort_handler_test.sv
// self-checking bench of the queued command abort handler
// assumes the host model and the bound checker beside it
`timescale 1ns/1ns
`include "qabort_defs.svh"
module queued_command_abort_handler_test
    import qabort_pkg::*;
;
    localparam int SLOTS = 32;
    typedef logic [SLOTS+1:0] note_t;
    logic mclk, nrst, clk_en, queuing_enabled, reg_wr, reg_rd, irq, cmd_valid;
    logic sdb_valid, error_valid, abort_request, deadline_request, other_command;
    logic [7:0] cmd_code, feature_cur, sector_count_cur, sector_number_cur, reg_wdata, reg_rdata;
    logic [4:0] max_slot, own;
    logic [3:0] reg_addr;
    logic [SLOTS-1:0] outstanding, streaming, finished, outstanding_command_mask, abort_slots;
    logic [SLOTS-1:0] o, s, f, hit, last;
    logic [31:0] rnd;
    note_t notes[$];
    logic [SLOTS-1:0] hits[$];
    int bad_count, comparisons;
    queued_command_abort_handler #(.SLOTS(SLOTS)) queued_command_abort_handler_i (
        .mclk(mclk), .nrst(nrst), .clk_en(clk_en), .cmd_valid(cmd_valid),
        .cmd_code(cmd_code), .feature_cur(feature_cur), .sector_count_cur(sector_count_cur),
        .sector_number_cur(sector_number_cur), .queuing_enabled(queuing_enabled),
        .max_slot(max_slot), .outstanding(outstanding), .streaming(streaming),
        .finished(finished), .sdb_valid(sdb_valid), .error_valid(error_valid),
        .outstanding_command_mask(outstanding_command_mask), .abort_request(abort_request),
        .abort_slots(abort_slots), .deadline_request(deadline_request),
        .other_command(other_command), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));
    host_model host_model_i (.mclk(mclk), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
        .feature_cur(feature_cur), .sector_count_cur(sector_count_cur),
        .sector_number_cur(sector_number_cur));
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task automatic check(input string name, input note_t seen, input note_t exp);
        comparisons++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge mclk);
        reg_wr    <= 1'b0;
    endtask
    task automatic reg_read(input logic [3:0] a, input logic [7:0] e);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge mclk);
        reg_rd   <= 1'b0;
        @(negedge mclk);
        check("register", note_t'(reg_rdata), note_t'(e));
    endtask
    task automatic reject(input logic q, input logic [7:0] feat, input logic [4:0] t);
        @(posedge mclk);
        queuing_enabled <= q;
        notes.push_back({2'b01, {SLOTS{1'b0}}});
        host_model_i.send(`CMD_QUEUE_MGMT, feat, 5'd5, t);
        queuing_enabled <= 1'b1;
    endtask
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // result watcher: kind in top bits, completion mask below
    always @(posedge mclk)
    begin
        if (sdb_valid || error_valid || deadline_request || other_command)
            check("result", {deadline_request | other_command, error_valid | other_command,
                  sdb_valid ? outstanding_command_mask : {SLOTS{1'b0}}},
                  notes.size() != 0 ? notes.pop_front() : '1);
        if (abort_request)
            check("slots", note_t'(abort_slots),
                  hits.size() != 0 ? note_t'(hits.pop_front()) : '1);
    end
    initial mclk = 1'b0;
    always #25 mclk = ~mclk;
    initial
    begin
        #100000;
        bad_count++;
        finish_test;
    end
    initial
    begin
        {nrst, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
        {clk_en, queuing_enabled, max_slot, rnd} = {2'b11, 5'd15, 32'h01c44eea};
        {outstanding, streaming, finished} = '0;
        repeat (3) @(posedge mclk);
        nrst <= 1'b1;
        reg_read(`REG_SUPPORT, 8'h0F);
        reg_read(`REG_STATUS, 8'h50);
        reg_write(`REG_CONTROL, 8'h01);
        // every abort type accepted, the last with nothing outstanding
        for (int t = 0; t < 5; t++)
        begin
            rnd = lfsr(rnd);
            own = {1'b0, rnd[3:0]};
            o = (t == 4) ? '0 : rnd & ~(32'h1 << own);
            rnd = lfsr(rnd);
            s = rnd;
            f = ~rnd & ~o & ~(32'h1 << own);
            hit = t == 1 ? o & s : t == 2 ? o & ~s : t == 3 ? o & (32'h1 << (own ^ 5'd1)) : o;
            last = (32'h1 << own) | hit | f;
            @(posedge mclk);
            {outstanding, streaming, finished} <= {o, s, f};
            notes.push_back({2'b00, last});
            hits.push_back(hit);
            host_model_i.send(`CMD_QUEUE_MGMT, {t == 4 ? 4'h0 : 4'(t), 4'h0}, own, own ^ 5'd1);
        end
        reg_read(`REG_STATUS, 8'h50);
        reg_read(`REG_LAST_MASK, last[7:0]);
        $display("accept tests done");
        reject(1'b0, 8'h00, 5'd6);
        reject(1'b1, 8'h30, 5'd5);
        reject(1'b1, 8'h30, 5'd20);
        reject(1'b1, 8'h90, 5'd6);
        reject(1'b1, 8'h02, 5'd6);
        reg_read(`REG_ERROR, 8'h04);
        reg_read(`REG_STATUS, 8'h51);
        $display("reject tests done");
        notes.push_back({2'b10, {SLOTS{1'b0}}});
        host_model_i.send(`CMD_QUEUE_MGMT, 8'h01, 5'd2, 5'd3);
        notes.push_back({2'b11, {SLOTS{1'b0}}});
        host_model_i.send(8'h60, 8'h00, 5'd2, 5'd3);
        $display("decode tests done");
        // sticky events, mask and write-one-to-clear of the interrupt status
        reg_read(`REG_IRQ_STATUS, 8'h03);
        check("irq masked", note_t'(irq), note_t'(1'b0));
        reg_write(`REG_IRQ_MASK, 8'h02);
        repeat (2) @(negedge mclk);
        check("irq unmasked", note_t'(irq), note_t'(1'b1));
        reg_write(`REG_IRQ_STATUS, 8'h03);
        repeat (2) @(negedge mclk);
        check("irq cleared", note_t'(irq), note_t'(1'b0));
        reg_read(`REG_IRQ_STATUS, 8'h00);
        // disabled handler and frozen clock enable both ignore a task file
        reg_write(`REG_CONTROL, 8'h00);
        host_model_i.send(`CMD_QUEUE_MGMT, 8'h00, 5'd2, 5'd3);
        reg_write(`REG_CONTROL, 8'h01);
        clk_en <= 1'b0;
        host_model_i.send(8'h60, 8'h00, 5'd2, 5'd3);
        clk_en <= 1'b1;
        reg_read(`REG_CONTROL, 8'h01);
        reg_read(4'hF, 8'h00);
        check("pending", note_t'(notes.size() + hits.size()), note_t'(0));
        $display("register tests done");
        finish_test;
    end
endmodule // queued_command_abort_handler_test
